// ===== pkg/fcs_pkg.sv
package fcs_pkg;
    // fuse byte geometry
    localparam int        FUSE_W        = 8;
    localparam logic      PROGRAMMED    = 1'b0;     // a programmed fuse reads as zero
    localparam logic      UNPROGRAMMED  = 1'b1;
    // factory contents of the two configuration bytes
    localparam logic [7:0] HIGH_DEFAULT = 8'hff;
    localparam logic [7:0] LOW_DEFAULT  = 8'h6a;
    localparam logic [7:0] WORK_UNUSED  = 8'hff;    // working copy before the first latch
    // high byte field positions
    localparam int        HI_SELF_PROG  = 4;
    localparam int        HI_DEBUG      = 3;
    localparam int        HI_BOD_HI     = 2;
    localparam int        HI_BOD_LO     = 1;
    localparam int        HI_RST_DIS    = 0;
    // low byte field positions
    localparam int        LO_SERIAL     = 7;
    localparam int        LO_EE_KEEP    = 6;
    localparam int        LO_WDT_ON     = 5;
    localparam int        LO_DIV8       = 4;
    localparam int        LO_SUT_HI     = 3;
    localparam int        LO_SUT_LO     = 2;
    localparam int        LO_CKS_HI     = 1;
    localparam int        LO_CKS_LO     = 0;
    // identification address space
    localparam int        SIG_ADDR_W    = 2;
    localparam logic [1:0] SIG_ADDR_0   = 2'h0;
    localparam logic [1:0] SIG_ADDR_1   = 2'h1;
    localparam logic [1:0] SIG_ADDR_2   = 2'h2;
    localparam logic [7:0] SIG_NONE     = 8'hff;    // unused identification address
    // signature-area calibration addresses (high byte of each word)
    localparam logic [1:0] CAL_ADDR_9M6 = 2'h0;
    localparam logic [1:0] CAL_ADDR_4M8 = 2'h1;
    // memory geometry
    localparam int        FLASH_PC_W    = 9;        // 512 words
    localparam int        FLASH_WORD_W  = 4;        // 16 words per page, 32 pages
    localparam int        EE_ADDR_W     = 6;        // 64 bytes
    localparam int        EE_BYTE_W     = 2;        // 4 bytes per page, 16 pages
endpackage

// ===== design/fcs_page_split.sv
// splits a linear address into page index and offset within the page
module fcs_page_split #(
    parameter int ADDR_W = 9,
    parameter int LOW_W  = 4
) (
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic [ADDR_W-1:0]   linearAddr,
    output logic      [LOW_W-1:0]    inPage,
    output logic      [ADDR_W-LOW_W-1:0] pageIndex
);
    logic [LOW_W-1:0]        inPage_r;          // offset within page
    logic [LOW_W-1:0]        inPage_nxt;
    logic [ADDR_W-LOW_W-1:0] page_r;            // page number
    logic [ADDR_W-LOW_W-1:0] page_nxt;

    ////////////////////////////////////////////////////////////////
    // low bits pick the entry, high bits the page
    always_comb begin
        inPage_nxt = linearAddr[LOW_W-1:0];
        page_nxt   = linearAddr[ADDR_W-1:LOW_W];
    end

    // registered outputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            inPage_r <= '0;
            page_r   <= '0;
        end else begin
            inPage_r <= inPage_nxt;
            page_r   <= page_nxt;
        end
    end

    assign inPage    = inPage_r;
    assign pageIndex = page_r;
endmodule

// ===== design/fcs_id_rom.sv
// three-byte identification code, readable whatever the lock state
module fcs_id_rom #(
    parameter logic [7:0] ID_BYTE0 = 8'h5a,     // value arbitrary
    parameter logic [7:0] ID_BYTE1 = 8'h01,     // value arbitrary
    parameter logic [7:0] ID_BYTE2 = 8'h02      // value arbitrary
) (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          readStrobe,
    input  wire logic [fcs_pkg::SIG_ADDR_W-1:0] readAddr,
    output logic      [7:0]                    readData,
    output logic                               readValid
);
    logic [7:0] data_r;                          // returned byte
    logic [7:0] data_nxt;
    logic       valid_r;                         // one-cycle answer flag
    logic       valid_nxt;

    ////////////////////////////////////////////////////////////////
    // address decode, no lock gating at all
    always_comb begin
        data_nxt  = data_r;
        valid_nxt = readStrobe;
        if (readStrobe) begin
            case (readAddr)
                fcs_pkg::SIG_ADDR_0: data_nxt = ID_BYTE0;
                fcs_pkg::SIG_ADDR_1: data_nxt = ID_BYTE1;
                fcs_pkg::SIG_ADDR_2: data_nxt = ID_BYTE2;
                default:             data_nxt = fcs_pkg::SIG_NONE;
            endcase
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            data_r  <= fcs_pkg::SIG_NONE;
            valid_r <= 1'b0;
        end else begin
            data_r  <= data_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign readData  = data_r;
    assign readValid = valid_r;
endmodule

// ===== design/fcs_fuse_store.sv
// Contract
// - programmed fuse reads 0, unprogrammed reads 1
// - high byte fields and all-ones default
// - low byte bits 7..4 and their defaults
// - low bits select start-up and clock source
// - serial programming cannot see serial-enable fuse
// - forced watchdog disables watchdog interrupt
// - lock bit one programmed blocks fuse writes
// - chip erase leaves fuses unchanged
// - firmware can read the fuse bytes
// - latch on programming entry, apply on exit
// - eeprom-keep fuse acts immediately when programmed
// - latch all fuses at normal power-up
// - every reset loads 9.6 MHz trim byte
// - identification code readable in any mode, locked
// - flash 32 pages of 16 words
// - eeprom 16 pages of 4 bytes
// - store-program instruction needs self-program fuse
module fcs_fuse_store #(
    parameter logic [7:0] TRIM_9M6 = 8'h80,      // calibration byte, signature word 0
    parameter logic [7:0] TRIM_4M8 = 8'h80       // calibration byte, signature word 1
) (
    input  wire logic                                clk,
    input  wire logic                                reset_n,
    input  wire logic                                coldStart,
    input  wire logic                                progModeActive,
    input  wire logic                                progSerialMode,
    input  wire logic                                progFuseWrite,
    input  wire logic                                progFuseRead,
    input  wire logic                                progSelHigh,
    input  wire logic [7:0]                          progWriteData,
    output logic      [7:0]                          progReadData,
    output logic                                     progReadValid,
    input  wire logic                                lockBitOne,
    input  wire logic                                chipErase,
    input  wire logic                                sigRead,
    input  wire logic [fcs_pkg::SIG_ADDR_W-1:0]      sigAddr,
    output logic      [7:0]                          sigData,
    output logic                                     sigValid,
    input  wire logic                                calRead,
    input  wire logic [1:0]                          calAddr,
    output logic      [7:0]                          calData,
    input  wire logic                                fwFuseRead,
    input  wire logic                                fwSelHigh,
    output logic      [7:0]                          fwFuseData,
    input  wire logic                                fwTrimWrite,
    input  wire logic [7:0]                          fwTrimData,
    output logic      [7:0]                          osc_trim_register,
    input  wire logic                                store_program_instruction,
    output logic                                     storeProgGrant,
    output logic                                     self_program_allow,
    output logic                                     onchip_debug_allow,
    output logic      [1:0]                          brownoutLevel,
    output logic                                     reset_pin_disable,
    output logic                                     watchdog_forced_on,
    output logic                                     watchdogIrqAllow,
    output logic                                     clock_divide_by_eight,
    output logic      [1:0]                          startupTime,
    output logic      [1:0]                          clockSource,
    output logic                                     serial_prog_allow,
    output logic                                     eeprom_keep_on_erase,
    input  wire logic [fcs_pkg::FLASH_PC_W-1:0]      flashCounter,
    output logic      [fcs_pkg::FLASH_WORD_W-1:0]    flash_word_in_page,
    output logic      [fcs_pkg::FLASH_PC_W-fcs_pkg::FLASH_WORD_W-1:0] flash_page_index,
    input  wire logic [fcs_pkg::EE_ADDR_W-1:0]       eepromAddr,
    output logic      [fcs_pkg::EE_BYTE_W-1:0]       eepromByteInPage,
    output logic      [fcs_pkg::EE_ADDR_W-fcs_pkg::EE_BYTE_W-1:0] eepromPageIndex
);

    ////////////////////////////////////////////////////////////////
    // nonvolatile cells
    logic [7:0] nvHigh_r;                        // stored high byte
    logic [7:0] nvHigh_nxt;
    logic [7:0] nvLow_r;                         // stored low byte
    logic [7:0] nvLow_nxt;
    logic       writeOk;                         // write may land

    // cells change only on an accepted programmer write
    always_comb begin
        nvHigh_nxt = nvHigh_r;
        nvLow_nxt  = nvLow_r;
        writeOk    = progFuseWrite && progModeActive
                     && (lockBitOne != fcs_pkg::PROGRAMMED);
        // chip erase has no term here at all
        if (writeOk) begin
            if (progSelHigh) begin
                nvHigh_nxt = progWriteData;
            end else begin
                nvLow_nxt = progWriteData;
                if (progSerialMode) begin
                    nvLow_nxt[fcs_pkg::LO_SERIAL] = nvLow_r[fcs_pkg::LO_SERIAL];
                end
            end
        end
    end

    // cells survive warm resets, take factory values on a cold one
    always_ff @(posedge clk) begin
        if (!reset_n && coldStart) begin
            nvHigh_r <= fcs_pkg::HIGH_DEFAULT;
            nvLow_r  <= fcs_pkg::LOW_DEFAULT;
        end else if (reset_n) begin
            nvHigh_r <= nvHigh_nxt;
            nvLow_r  <= nvLow_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // working copies and latch events
    logic [7:0] workHigh_r;                      // copy seen by the device
    logic [7:0] workHigh_nxt;
    logic [7:0] workLow_r;
    logic [7:0] workLow_nxt;
    logic       progPrev_r;                      // last programming-mode level
    logic       progPrev_nxt;
    logic       powerUp_r;                       // latch owed after reset
    logic       powerUp_nxt;
    logic       latchNow;                        // any latch event

    // latch on power-up, on entry and on exit of programming mode
    always_comb begin
        progPrev_nxt = progModeActive;
        powerUp_nxt  = 1'b0;
        latchNow     = (powerUp_r && !progModeActive)
                       || (progModeActive != progPrev_r);
        workHigh_nxt = workHigh_r;
        workLow_nxt  = workLow_r;
        if (latchNow) begin
            workHigh_nxt = nvHigh_r;
            workLow_nxt  = nvLow_r;
        end
    end

    // working registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            workHigh_r <= fcs_pkg::WORK_UNUSED;
            workLow_r  <= fcs_pkg::WORK_UNUSED;
            progPrev_r <= 1'b0;
            powerUp_r  <= 1'b1;
        end else begin
            workHigh_r <= workHigh_nxt;
            workLow_r  <= workLow_nxt;
            progPrev_r <= progPrev_nxt;
            powerUp_r  <= powerUp_nxt;
        end
    end

    // decoded controls: single-bit ones are high when the fuse is programmed, except watchdogIrqAllow; multi-bit fields pass the raw bits
    assign self_program_allow    = workHigh_r[fcs_pkg::HI_SELF_PROG] == fcs_pkg::PROGRAMMED;
    assign onchip_debug_allow    = workHigh_r[fcs_pkg::HI_DEBUG] == fcs_pkg::PROGRAMMED;
    assign brownoutLevel         = workHigh_r[fcs_pkg::HI_BOD_HI:fcs_pkg::HI_BOD_LO];
    assign reset_pin_disable     = workHigh_r[fcs_pkg::HI_RST_DIS] == fcs_pkg::PROGRAMMED;
    assign serial_prog_allow     = workLow_r[fcs_pkg::LO_SERIAL] == fcs_pkg::PROGRAMMED;
    assign watchdog_forced_on    = workLow_r[fcs_pkg::LO_WDT_ON] == fcs_pkg::PROGRAMMED;
    assign watchdogIrqAllow      = !watchdog_forced_on;
    assign clock_divide_by_eight = workLow_r[fcs_pkg::LO_DIV8] == fcs_pkg::PROGRAMMED;
    assign startupTime           = workLow_r[fcs_pkg::LO_SUT_HI:fcs_pkg::LO_SUT_LO];
    assign clockSource           = workLow_r[fcs_pkg::LO_CKS_HI:fcs_pkg::LO_CKS_LO];
    // eeprom keep bypasses the latch once the cell is programmed
    assign eeprom_keep_on_erase  = (workLow_r[fcs_pkg::LO_EE_KEEP] == fcs_pkg::PROGRAMMED)
                                   || (nvLow_r[fcs_pkg::LO_EE_KEEP] == fcs_pkg::PROGRAMMED);
    assign storeProgGrant        = store_program_instruction && self_program_allow;

    ////////////////////////////////////////////////////////////////
    // read ports and oscillator trim
    logic [7:0] progRd_r;                        // programmer read data
    logic [7:0] progRd_nxt;
    logic       progRdV_r;
    logic       progRdV_nxt;
    logic [7:0] fwRd_r;                          // firmware read data
    logic [7:0] fwRd_nxt;
    logic [7:0] calRd_r;                         // calibration read data
    logic [7:0] calRd_nxt;
    logic [7:0] trim_r;                          // oscillator trim
    logic [7:0] trim_nxt;

    // raw cell bits are returned, so a zero is a programmed fuse
    always_comb begin
        progRd_nxt  = progRd_r;
        progRdV_nxt = progFuseRead;
        fwRd_nxt    = fwRd_r;
        calRd_nxt   = calRd_r;
        trim_nxt    = trim_r;
        if (progFuseRead) begin
            progRd_nxt = progSelHigh ? nvHigh_r : nvLow_r;
            if (!progSelHigh && progSerialMode) begin
                progRd_nxt[fcs_pkg::LO_SERIAL] = fcs_pkg::UNPROGRAMMED;
            end
        end
        if (fwFuseRead) begin
            fwRd_nxt = fwSelHigh ? nvHigh_r : nvLow_r;
        end
        if (calRead) begin
            case (calAddr)
                fcs_pkg::CAL_ADDR_9M6: calRd_nxt = TRIM_9M6;
                fcs_pkg::CAL_ADDR_4M8: calRd_nxt = TRIM_4M8;
                default:               calRd_nxt = fcs_pkg::SIG_NONE;
            endcase
        end
        // only firmware ever puts the 4.8 MHz byte into the trim
        if (fwTrimWrite) begin
            trim_nxt = fwTrimData;
        end
    end

    // read and trim registers; every reset reloads the trim
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            progRd_r  <= fcs_pkg::SIG_NONE;
            progRdV_r <= 1'b0;
            fwRd_r    <= fcs_pkg::SIG_NONE;
            calRd_r   <= fcs_pkg::SIG_NONE;
            trim_r    <= TRIM_9M6;
        end else begin
            progRd_r  <= progRd_nxt;
            progRdV_r <= progRdV_nxt;
            fwRd_r    <= fwRd_nxt;
            calRd_r   <= calRd_nxt;
            trim_r    <= trim_nxt;
        end
    end

    assign progReadData      = progRd_r;
    assign progReadValid     = progRdV_r;
    assign fwFuseData        = fwRd_r;
    assign calData           = calRd_r;
    assign osc_trim_register = trim_r;

    ////////////////////////////////////////////////////////////////
    // identification code and memory geometry
    fcs_id_rom u_id (
        .clk        (clk),
        .reset_n    (reset_n),
        .readStrobe (sigRead),
        .readAddr   (sigAddr),
        .readData   (sigData),
        .readValid  (sigValid)
    );

    fcs_page_split #(
        .ADDR_W (fcs_pkg::FLASH_PC_W),
        .LOW_W  (fcs_pkg::FLASH_WORD_W)
    ) u_flash_split (
        .clk        (clk),
        .reset_n    (reset_n),
        .linearAddr (flashCounter),
        .inPage     (flash_word_in_page),
        .pageIndex  (flash_page_index)
    );

    fcs_page_split #(
        .ADDR_W (fcs_pkg::EE_ADDR_W),
        .LOW_W  (fcs_pkg::EE_BYTE_W)
    ) u_ee_split (
        .clk        (clk),
        .reset_n    (reset_n),
        .linearAddr (eepromAddr),
        .inPage     (eepromByteInPage),
        .pageIndex  (eepromPageIndex)
    );

    ////////////////////////////////////////////////////////////////
    // checks
    a_locked_write_dropped: assert property (@(posedge clk) disable iff (!reset_n)
        progFuseWrite && lockBitOne == fcs_pkg::PROGRAMMED |=> $stable(nvHigh_r) && $stable(nvLow_r))
        else $error("fuse cell changed while locked");

    a_serial_bit_kept: assert property (@(posedge clk) disable iff (!reset_n)
        progFuseWrite && progSerialMode && !progSelHigh
        |=> nvLow_r[fcs_pkg::LO_SERIAL] == $past(nvLow_r[fcs_pkg::LO_SERIAL]))
        else $error("serial enable fuse changed over serial link");

    a_serial_read_hidden: assert property (@(posedge clk) disable iff (!reset_n)
        progFuseRead && progSerialMode && !progSelHigh |=> progReadData[fcs_pkg::LO_SERIAL] == 1'b1)
        else $error("serial enable fuse visible over serial link");

    a_erase_keeps_fuses: assert property (@(posedge clk) disable iff (!reset_n)
        chipErase && !progFuseWrite |=> $stable(nvLow_r) && $stable(nvHigh_r))
        else $error("chip erase altered fuses");

    a_entry_latch_value: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(progModeActive) |=> workLow_r == $past(nvLow_r) && workHigh_r == $past(nvHigh_r))
        else $error("fuses not latched on programming entry");

    a_prog_copy_frozen: assert property (@(posedge clk) disable iff (!reset_n)
        progModeActive [*3] |-> $stable(workLow_r) && $stable(workHigh_r))
        else $error("working copy moved inside programming mode");

    a_keep_immediate: assert property (@(posedge clk) disable iff (!reset_n)
        nvLow_r[fcs_pkg::LO_EE_KEEP] == fcs_pkg::PROGRAMMED |-> eeprom_keep_on_erase)
        else $error("eeprom keep not immediate");

    a_powerup_latch: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(powerUp_r == 1'b0) && !$past(progModeActive) |-> workLow_r == $past(nvLow_r))
        else $error("power-up latch missing");

    a_watchdog_irq_off: assert property (@(posedge clk) disable iff (!reset_n)
        workLow_r[fcs_pkg::LO_WDT_ON] == fcs_pkg::PROGRAMMED |-> !watchdogIrqAllow)
        else $error("watchdog interrupt left on");

    a_store_prog_gated: assert property (@(posedge clk) disable iff (!reset_n)
        workHigh_r[fcs_pkg::HI_SELF_PROG] != fcs_pkg::PROGRAMMED |-> !storeProgGrant)
        else $error("store-program granted without fuse");

    a_trim_after_reset: assert property (@(posedge clk)
        $rose(reset_n) |-> osc_trim_register == TRIM_9M6)
        else $error("trim not reloaded by reset");

    a_fw_read_value: assert property (@(posedge clk) disable iff (!reset_n)
        fwFuseRead && fwSelHigh && !progFuseWrite |=> fwFuseData == $past(nvHigh_r))
        else $error("firmware fuse read wrong");

    c_fuse_written: cover property (@(posedge clk) disable iff (!reset_n) writeOk);
    c_prog_exit_latch: cover property (@(posedge clk) disable iff (!reset_n) $fell(progModeActive));
    c_trim_by_fw: cover property (@(posedge clk) disable iff (!reset_n) fwTrimWrite);
    c_locked_attempt: cover property (@(posedge clk) disable iff (!reset_n)
        progFuseWrite && lockBitOne == fcs_pkg::PROGRAMMED);
endmodule

// ===== tb/fcs_prog_model.sv
// external programmer: sessions, fuse bytes, lock level and erase pulses
module fcs_prog_model (
    input  wire logic       clk,
    input  wire logic [7:0] progReadData,
    input  wire logic       progReadValid,
    output logic            progModeActive,
    output logic            progSerialMode,
    output logic            progFuseWrite,
    output logic            progFuseRead,
    output logic            progSelHigh,
    output logic [7:0]      progWriteData,
    output logic            lockBitOne,
    output logic            chipErase
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////
    // idle, unlocked, debug fuse never touched when locking
    initial begin
        {progModeActive, progSerialMode, progFuseWrite, progFuseRead, progSelHigh, chipErase} = 6'h00;
        progWriteData = 8'h00;
        lockBitOne = 1'b1;
    end
    // session level, wire mode and lock, all three set on the same negedge
    task automatic mode(input logic on, input logic serial, input logic locked);
        @(negedge clk);
        progSerialMode = serial;
        progModeActive = on;
        lockBitOne = ~locked;
    endtask
    // one fuse byte written or read, answer one cycle later
    task automatic xfer(input logic w, input logic hi, input logic [7:0] din, output logic [7:0] q, output logic v);
        @(negedge clk);
        progSelHigh = hi;
        progWriteData = din;
        {progFuseWrite, progFuseRead} = {w, ~w};
        @(negedge clk);
        {progFuseWrite, progFuseRead} = 2'b00;
        progWriteData = ~din; // released bus does not hold its value
        q = progReadData;
        v = progReadValid;
    endtask
    // single erase pulse
    task automatic erase();
        @(negedge clk);
        chipErase = 1'b1;
        @(negedge clk);
        chipErase = 1'b0;
    endtask
endmodule

// ===== tb/testbench.sv
// fuse store bench: defaults, latching, serial hiding, lock, trim, pages
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] TRIM96 = 8'h9c;
    localparam logic [7:0] TRIM48 = 8'h47;
    logic clk = 1'b0, reset_n = 1'b0, coldStart = 1'b1, store_program_instruction = 1'b0, v;
    logic sigRead = 1'b0, calRead = 1'b0, fwFuseRead = 1'b0, fwSelHigh = 1'b0, fwTrimWrite = 1'b0;
    logic [7:0] fwTrimData = 8'h00, progWriteData, progReadData, sigData, calData, fwFuseData, osc_trim_register, d;
    logic [1:0] sigAddr = 2'h0, calAddr = 2'h0, brownoutLevel, startupTime, clockSource, eepromByteInPage;
    logic [8:0] flashCounter = 9'h000;
    logic [5:0] eepromAddr = 6'h00;
    logic [4:0] flash_page_index;
    logic [3:0] flash_word_in_page, eepromPageIndex;
    logic progModeActive, progSerialMode, progFuseWrite, progFuseRead, progSelHigh, lockBitOne, chipErase;
    logic progReadValid, sigValid, storeProgGrant, self_program_allow, onchip_debug_allow, reset_pin_disable;
    logic watchdog_forced_on, watchdogIrqAllow, clock_divide_by_eight, serial_prog_allow, eeprom_keep_on_erase;
    int n_fail = 0, checks_done = 0, cycles = 0;
    ////////////////////////////////////////
    fcs_fuse_store #(.TRIM_9M6(TRIM96), .TRIM_4M8(TRIM48)) dut (.clk, .reset_n, .coldStart, .progModeActive,
        .progSerialMode, .progFuseWrite, .progFuseRead, .progSelHigh, .progWriteData, .progReadData, .progReadValid,
        .lockBitOne, .chipErase, .sigRead, .sigAddr, .sigData, .sigValid, .calRead, .calAddr, .calData, .fwFuseRead,
        .fwSelHigh, .fwFuseData, .fwTrimWrite, .fwTrimData, .osc_trim_register, .store_program_instruction,
        .storeProgGrant,
        .self_program_allow, .onchip_debug_allow, .brownoutLevel, .reset_pin_disable, .watchdog_forced_on,
        .watchdogIrqAllow, .clock_divide_by_eight, .startupTime, .clockSource, .serial_prog_allow, .eeprom_keep_on_erase,
        .flashCounter, .flash_word_in_page, .flash_page_index, .eepromAddr, .eepromByteInPage, .eepromPageIndex);
    fcs_prog_model prog (.clk, .progReadData, .progReadValid, .progModeActive, .progSerialMode, .progFuseWrite,
        .progFuseRead, .progSelHigh, .progWriteData, .lockBitOne, .chipErase);
    always #12.5 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one-cycle read: kind 0 identity, 1 trim byte, 2 firmware fuse byte
    task automatic sideRead(input int kind, input logic [1:0] a);
        @(negedge clk);
        {sigAddr, calAddr, fwSelHigh} = {a, a, a[0]};
        {sigRead, calRead, fwFuseRead} = {kind == 0, kind == 1, kind == 2};
        @(negedge clk);
        {sigRead, calRead, fwFuseRead} = 3'h0;
        d = (kind == 0) ? sigData : (kind == 1) ? calData : fwFuseData;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        // factory bytes and decoded controls after power-up latch
        sideRead(2, 2'h0);
        check(d, 8'h6a);
        sideRead(2, 2'h1);
        check(d, 8'hff);
        check({clock_divide_by_eight, serial_prog_allow, startupTime, clockSource}, 6'h3a);
        check({brownoutLevel, reset_pin_disable, onchip_debug_allow, self_program_allow}, 5'h18);
        check({watchdog_forced_on, watchdogIrqAllow, eeprom_keep_on_erase, osc_trim_register}, {3'h2, TRIM96});
        // writes in session stay hidden until exit, except the eeprom keep
        store_program_instruction = 1'b1;
        prog.mode(1'b1, 1'b0, 1'b0);
        prog.xfer(1'b1, 1'b1, 8'hef, d, v);
        prog.xfer(1'b1, 1'b0, 8'h0a, d, v);
        check(eeprom_keep_on_erase, 1'b1);
        check({self_program_allow, watchdog_forced_on, storeProgGrant}, 3'h0);
        prog.xfer(1'b0, 1'b1, 8'h00, d, v);
        check({v, d}, 9'h1ef);
        prog.mode(1'b0, 1'b0, 1'b0);
        repeat (2) @(negedge clk);
        check({self_program_allow, watchdog_forced_on, watchdogIrqAllow, storeProgGrant}, 4'hd);
        store_program_instruction = 1'b0;
        // serial session hides the serial-enable fuse
        prog.mode(1'b1, 1'b1, 1'b0);
        prog.xfer(1'b0, 1'b0, 8'h00, d, v);
        check(d, 8'h8a);
        prog.xfer(1'b1, 1'b0, 8'hca, d, v);
        prog.mode(1'b0, 1'b0, 1'b0);
        sideRead(2, 2'h0);
        check(d, 8'h4a);
        // locked: write refused, erase harmless, identity still readable
        prog.mode(1'b1, 1'b0, 1'b1);
        prog.xfer(1'b1, 1'b1, 8'h00, d, v);
        prog.erase();
        for (int i = 0; i < 3; i++) begin
            sideRead(0, i[1:0]);
            check({sigValid, d}, {1'b1, (i == 0) ? 8'h5a : i[7:0]});
        end
        prog.mode(1'b0, 1'b0, 1'b0);
        sideRead(2, 2'h1);
        check(d, 8'hef);
        // trim bytes, firmware override, warm reset reload
        sideRead(1, 2'h1);
        check(d, TRIM48);
        @(negedge clk) fwTrimData = TRIM48;
        fwTrimWrite = 1'b1;
        @(negedge clk) fwTrimWrite = 1'b0;
        check(osc_trim_register, TRIM48);
        coldStart = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        check({self_program_allow, osc_trim_register}, {1'b1, TRIM96});
        // page geometry at sample addresses 0x1a7 and 0x2d
        flashCounter = 9'h1a7;
        eepromAddr = 6'h2d;
        @(negedge clk);
        check({flash_page_index, flash_word_in_page}, {5'h1a, 4'h7});
        check({eepromPageIndex, eepromByteInPage}, {4'hb, 2'h1});
        final_report();
    end
endmodule
